//--- verilog/io_wait_and_analog_sample_cmds.sv
// Top of the wait and sampling command unit: AXI4-Lite slave, command
// sequencer, I/O line control and data register file.
// Assumes an AXI4-Lite master on aclk and asynchronous I/O pins.
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module io_wait_and_analog_sample_cmds
	import sv_cmd_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC // Clocks per servo tick
)(
	input logic aclk, // System clock, 100 MHz
	input logic aresetn, // Synchronous reset, active low
	input logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input logic [ADDR_W-1:0] s_axi_awaddr, // Write byte address
	input logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	input logic [31:0] s_axi_wdata, // Write data
	input logic [3:0] s_axi_wstrb, // Byte enables
	output logic s_axi_bvalid, // Write response valid
	input logic s_axi_bready, // Write response ready
	output logic [1:0] s_axi_bresp, // Write response
	input logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	input logic [ADDR_W-1:0] s_axi_araddr, // Read byte address
	output logic s_axi_rvalid, // Read data valid
	input logic s_axi_rready, // Read data ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	input logic [N_ADC*ADC_W-1:0] adc_sample, // Converter words
	input logic [15:0] velocity_reading, // Signed velocity
	input logic [15:0] torque_reading, // Signed torque
	input logic [15:0] poserr_reading, // Signed position error
	input logic [N_IO-1:0] io_in, // Line pin levels
	output logic [N_IO-1:0] io_out, // Line drive levels
	output logic [N_IO-1:0] io_oe // Line drive enables
);
	typedef struct packed
	{
		logic [N_IO-1:0] io_meta;
		logic [N_IO-1:0] io_sync;
		logic [N_IO-1:0] out_lvl;
		logic [N_IO-1:0] out_en;
		cmd_state_t st;
		logic [7:0] code;
		logic [15:0] p1;
		logic [15:0] p2;
		logic [3:0] wl_line;
		logic wl_lvl;
		logic ack;
		logic err;
		logic [3:0] samp_ch;
		logic [11:0] samp_coef;
		logic [4:0] samp_reg;
		logic aw_hold;
		logic [ADDR_W-1:0] awa;
		logic w_hold;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} top_t;
	top_t s_ff;
	top_t nxt_s;
	logic [31:0] dreg [N_DREG];
	logic [N_ADC-1:0][14:0] filt;
	logic [31:0] chv [16];
	logic tick;
	logic [31:0] delay_count;
	logic do_wr, issue, abort, busy, line_ok, mode_ok, wdreg;
	logic [3:0] line_idx;
	logic [N_IO-1:0] line_mask;
	logic [31:0] wmask, rd_val;
	logic rd_ok;
	logic set_ack, set_err, clr_ack, clr_err, samp_go;
	logic [31:0] samp_src;
	logic wr_en;
	logic [4:0] wr_idx;
	logic [31:0] wr_dat, y_old;
	logic signed [48:0] prod;
	// ==================================================
	// Tick, delay counter and background filters
	servo_tick_if tk();
	servo_tick_delay #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.tk(tk)
	);
	analog_filter_bank u_filt (
		.aclk(aclk),
		.aresetn(aresetn),
		.tk(tk),
		.adc_sample(adc_sample),
		.filt(filt)
	);
	assign tick = tk.tick;
	assign delay_count = tk.delay_count;
	// Register 5 is the delay counter, so every write to it reloads
	assign tk.delay_load = wr_en && wr_idx == DELAY_REG;
	assign tk.delay_val = wr_dat;
	// ==================================================
	// Channel sources
	assign chv[0] = 32'h0;
	for (genvar g = 1; g <= N_ADC; g++)
	begin : g_chv
		assign chv[g] = {17'h0, filt[g-1]};
	end
	assign chv[CH_VEL] = {{16{velocity_reading[15]}}, velocity_reading};
	assign chv[CH_TRQ] = {{16{torque_reading[15]}}, torque_reading};
	assign chv[CH_PERR] = {{16{poserr_reading[15]}}, poserr_reading};
	function automatic logic [31:0] rd_dreg(input logic [4:0] i);
		rd_dreg = (i == DELAY_REG) ? delay_count : dreg[i];
	endfunction
	// ==================================================
	// Decode helpers
	assign do_wr = s_ff.aw_hold && s_ff.w_hold;
	assign wdreg = s_ff.awa[ADDR_W-1:7] == DREG_BASE;
	assign wmask = {{8{s_ff.ws[3]}}, {8{s_ff.ws[2]}}, {8{s_ff.ws[1]}}, {8{s_ff.ws[0]}}};
	assign issue = do_wr && s_ff.awa == OFF_GO && s_ff.ws[0] && s_ff.wd[GO_ISSUE_BIT];
	assign abort = do_wr && s_ff.awa == OFF_GO && s_ff.ws[0] && s_ff.wd[GO_ABORT_BIT];
	assign clr_ack = do_wr && s_ff.awa == OFF_STAT && s_ff.ws[0] && s_ff.wd[ST_ACK_BIT];
	assign clr_err = do_wr && s_ff.awa == OFF_STAT && s_ff.ws[0] && s_ff.wd[ST_ERR_BIT];
	assign busy = s_ff.st != S_IDLE;
	assign line_ok = s_ff.p1 >= 16'h0001 && s_ff.p1 <= 16'(N_IO);
	assign line_idx = s_ff.p1[3:0] - 4'h1;
	assign line_mask = N_IO'(1) << line_idx;
	assign mode_ok = s_ff.p2 == MODE_INPUT || s_ff.p2[15:1] == 15'h0;
	assign y_old = rd_dreg(s_ff.samp_reg);
	assign samp_src = chv[s_ff.samp_ch];
	// Extra low pass: y += (x - y) * coef / 65536, only upper 12 coef bits given
	assign prod = $signed(samp_src - y_old) * $signed({1'b0, s_ff.samp_coef, 4'h0});
	// ==================================================
	// Bus, sequencer and line control
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.io_meta = io_in;
		nxt_s.io_sync = s_ff.io_meta;
		set_ack = 1'b0;
		set_err = 1'b0;
		wr_en = 1'b0;
		wr_idx = 5'h0;
		wr_dat = 32'h0;
		samp_go = 1'b0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			nxt_s.aw_hold = 1'b1;
			nxt_s.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			nxt_s.w_hold = 1'b1;
			nxt_s.wd = s_axi_wdata;
			nxt_s.ws = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			nxt_s.bvalid = 1'b0;
		// Both halves in hand: perform the write and answer
		if (do_wr)
		begin
			nxt_s.aw_hold = 1'b0;
			nxt_s.w_hold = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = RESP_OKAY;
			if (wdreg)
			begin
				wr_en = 1'b1;
				wr_idx = s_ff.awa[6:2];
				wr_dat = (rd_dreg(s_ff.awa[6:2]) & ~wmask) | (s_ff.wd & wmask);
			end
			else if (s_ff.awa == OFF_CODE)
				nxt_s.code = s_ff.ws[0] ? s_ff.wd[7:0] : s_ff.code;
			else if (s_ff.awa == OFF_P1)
				nxt_s.p1 = (s_ff.p1 & wmask[15:0]) ^ ((s_ff.p1 ^ s_ff.wd[15:0]) & wmask[15:0])
					| (s_ff.p1 & ~wmask[15:0]);
			else if (s_ff.awa == OFF_P2)
				nxt_s.p2 = (s_ff.p2 & ~wmask[15:0]) | (s_ff.wd[15:0] & wmask[15:0]);
			else if (s_ff.awa != OFF_GO && s_ff.awa != OFF_STAT)
				nxt_s.bresp = RESP_SLVERR;
		end
		// Level waits are only re-checked on the tick, delay waits every cycle; no timeout exists
		case (s_ff.st)
			S_WLVL:
				if (tick && s_ff.io_sync[s_ff.wl_line] == s_ff.wl_lvl)
				begin
					nxt_s.st = S_IDLE;
					set_ack = 1'b1;
				end
			S_WDLY:
				if (delay_count == 32'h0)
				begin
					nxt_s.st = S_IDLE;
					set_ack = 1'b1;
				end
			default:
				;
		endcase
		if (abort)
			nxt_s.st = S_IDLE;
		else if (issue)
		begin
			// Only the immediate line configuration may run beside a wait
			if (busy && s_ff.code != CMD_CFG_IMM)
				set_err = 1'b1;
			else
				case (s_ff.code)
					CMD_CFG_IMM, CMD_CFG:
						if (!line_ok || !mode_ok)
							set_err = 1'b1;
						else
						begin
							nxt_s.out_en = (s_ff.p2 == MODE_INPUT) ? (s_ff.out_en & ~line_mask)
								: (s_ff.out_en | line_mask);
							if (s_ff.p2 != MODE_INPUT)
								nxt_s.out_lvl = s_ff.p2[0] ? (s_ff.out_lvl | line_mask)
									: (s_ff.out_lvl & ~line_mask);
							set_ack = 1'b1;
						end
					CMD_WAIT_LVL:
						if (!line_ok)
							set_err = 1'b1;
						else if (s_ff.io_sync[line_idx] == s_ff.p2[0])
							set_ack = 1'b1;
						else
						begin
							nxt_s.st = S_WLVL;
							nxt_s.wl_line = line_idx;
							nxt_s.wl_lvl = s_ff.p2[0];
						end
					CMD_WAIT_DELAY:
						if (delay_count == 32'h0)
							set_ack = 1'b1;
						else
							nxt_s.st = S_WDLY;
					CMD_DELAY_LOAD:
					begin
						wr_en = 1'b1;
						wr_idx = DELAY_REG;
						// Negative starts a free countdown, positive also waits it out
						if (s_ff.p1[15])
						begin
							wr_dat = {16'h0, 16'h0 - s_ff.p1};
							set_ack = 1'b1;
						end
						else
						begin
							wr_dat = {16'h0, s_ff.p1};
							nxt_s.st = S_WDLY;
						end
					end
					CMD_CONT_SAMPLE:
						if (s_ff.p2[15:5] != 11'h0)
							set_err = 1'b1;
						else
						begin
							nxt_s.samp_ch = s_ff.p1[3:0];
							nxt_s.samp_coef = s_ff.p1[15:4];
							nxt_s.samp_reg = s_ff.p2[4:0];
							set_ack = 1'b1;
						end
					CMD_ONE_SAMPLE:
						if (s_ff.p2[15:5] != 11'h0)
							set_err = 1'b1;
						else
						begin
							wr_en = 1'b1;
							wr_idx = s_ff.p2[4:0];
							wr_dat = chv[s_ff.p1[3:0]];
							set_ack = 1'b1;
						end
					default:
						set_err = 1'b1;
				endcase
		end
		// One continuous read; a tick that meets another write drops a sample
		samp_go = tick && s_ff.samp_ch != 4'h0 && !wr_en;
		if (samp_go)
		begin
			wr_en = 1'b1;
			wr_idx = s_ff.samp_reg;
			wr_dat = (s_ff.samp_coef == 12'h0) ? chv[s_ff.samp_ch] : y_old + 32'(prod >>> 16);
		end
		// Hardware set wins over a software clear
		nxt_s.ack = (s_ff.ack & ~clr_ack) | set_ack;
		nxt_s.err = (s_ff.err & ~clr_err) | set_err;
		if (s_axi_arvalid && s_axi_arready)
		begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rdata = rd_val;
			nxt_s.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_ff.rvalid && s_axi_rready)
			nxt_s.rvalid = 1'b0;
	end
	// ==================================================
	// Read decode
	always_comb
	begin
		rd_ok = 1'b1;
		rd_val = 32'h0;
		if (s_axi_araddr[ADDR_W-1:7] == DREG_BASE)
			rd_val = rd_dreg(s_axi_araddr[6:2]);
		else
			case (s_axi_araddr)
				OFF_CODE: rd_val = {24'h0, s_ff.code};
				OFF_P1: rd_val = {16'h0, s_ff.p1};
				OFF_P2: rd_val = {16'h0, s_ff.p2};
				OFF_GO: rd_val = 32'h0;
				OFF_STAT: rd_val = {20'h0, s_ff.samp_ch, 3'h0, s_ff.st == S_WDLY,
					s_ff.st == S_WLVL, s_ff.err, s_ff.ack, busy};
				OFF_IO_IN: rd_val = {18'h0, s_ff.io_sync};
				OFF_IO_DIR: rd_val = {2'h0, s_ff.out_en, 2'h0, s_ff.out_lvl};
				default: rd_ok = 1'b0;
			endcase
	end
	// ==================================================
	// State and register file
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			// All zero is no legal state code, so idle is set apart
			s_ff <= '0;
			s_ff.st <= S_IDLE;
		end
		else
			s_ff <= nxt_s;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			for (int i = 0; i < N_DREG; i++)
				dreg[i] <= 32'h0;
		else if (wr_en && wr_idx != DELAY_REG)
			dreg[wr_idx] <= wr_dat;
	end
	assign s_axi_awready = !s_ff.aw_hold && !s_ff.bvalid;
	assign s_axi_wready = !s_ff.w_hold && !s_ff.bvalid;
	assign s_axi_bvalid = s_ff.bvalid;
	assign s_axi_bresp = s_ff.bresp;
	assign s_axi_arready = !s_ff.rvalid;
	assign s_axi_rvalid = s_ff.rvalid;
	assign s_axi_rdata = s_ff.rdata;
	assign s_axi_rresp = s_ff.rresp;
	assign io_out = s_ff.out_lvl;
	assign io_oe = s_ff.out_en;
	// ==================================================
	// Checks
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_lvl_hold;
		(s_ff.st == S_WLVL && !tick && !abort) |=> s_ff.st == S_WLVL;
	endproperty
	a_lvl_hold: assert property (p_lvl_hold) else $error("level wait left off tick");
	property p_lvl_exit;
		(s_ff.st == S_WLVL && tick && s_ff.io_sync[s_ff.wl_line] == s_ff.wl_lvl)
			|=> (s_ff.st == S_IDLE && s_ff.ack);
	endproperty
	a_lvl_exit: assert property (p_lvl_exit) else $error("met level not acked");
	property p_lvl_now;
		(issue && !abort && !busy && s_ff.code == CMD_WAIT_LVL && line_ok
			&& s_ff.io_sync[line_idx] == s_ff.p2[0]) |=> (s_ff.st == S_IDLE && s_ff.ack);
	endproperty
	a_lvl_now: assert property (p_lvl_now) else $error("matching level still waited");
	property p_delay_hold;
		(s_ff.st == S_WDLY && delay_count != 32'h0 && !abort) |=> s_ff.st == S_WDLY;
	endproperty
	a_delay_hold: assert property (p_delay_hold) else $error("delay wait left early");
	property p_delay_exit;
		(s_ff.st == S_WDLY && delay_count == 32'h0) |=> s_ff.st == S_IDLE;
	endproperty
	a_delay_exit: assert property (p_delay_exit) else $error("delay wait stuck at zero");
	property p_delay_wr;
		(do_wr && wdreg && s_ff.awa[6:2] == DELAY_REG && s_ff.ws == 4'hF)
			|=> delay_count == $past(s_ff.wd);
	endproperty
	a_delay_wr: assert property (p_delay_wr) else $error("bus write missed counter");
	property p_cii_busy;
		(issue && !abort && busy && s_ff.code == CMD_CFG_IMM && line_ok && s_ff.p2 == 16'h0001)
			|=> ((s_ff.out_en & s_ff.out_lvl & $past(line_mask)) == $past(line_mask));
	endproperty
	a_cii_busy: assert property (p_cii_busy) else $error("config refused while busy");
	property p_io_reset;
		$rose(aresetn) |-> (s_ff.out_en == '0 && io_oe == '0);
	endproperty
	a_io_reset: assert property (p_io_reset) else $error("line driven after reset");
	property p_samp_store;
		(samp_go && s_ff.samp_coef == 12'h0 && s_ff.samp_reg != DELAY_REG)
			|=> dreg[$past(s_ff.samp_reg)] == $past(samp_src);
	endproperty
	a_samp_store: assert property (p_samp_store) else $error("tick sample not stored");
	c_lvl_wait: cover property (s_ff.st == S_WLVL ##1 s_ff.st == S_IDLE);
	c_delay_wait: cover property (s_ff.st == S_WDLY ##1 s_ff.st == S_IDLE);
	c_cii_busy: cover property (issue && busy && s_ff.code == CMD_CFG_IMM);
endmodule

//--- verilog/sv_cmd_pkg.sv
// Constants and types of the wait and analog sampling command unit.
// Assumes a 100 MHz aclk and command words written over AXI4-Lite.
// Function
// - Check input level once per servo tick
// - Unmet level wait stalls with no timeout
// - Level already matching continues at once
// - Level wait is code 194, line and level
// - Delay wait stalls until register 5 zero
// - Negative delay load or write starts countdown
// - Any register write may load the counter; here only writes to register 5 load it
// - Delay wait is single word code 141
// - Continuous read refreshes register every tick; a tick that meets another register write drops that sample
// - All analog channels filtered in background
// - Ten bit sample, filtered, times 32
// - Low nibble channel, upper twelve filter coefficient
// - Channel codes decode to their sources
// - Continuous read is code 207 with register
// - Single read stores one scaled sample
// - Single read is code 193, channel, register
// - Immediate line configuration accepted any time
// - Mode -1 input, 0 low, 1 high
// - All lines are inputs after reset
package sv_cmd_pkg;
	// ==================================================
	// Timing
	localparam int CLK_MHZ = 100;
	localparam int TICK_US = 120;
	localparam int TICK_CYC = TICK_US * CLK_MHZ;
	localparam int FILTER_US = 5000;
	localparam int FILT_SHIFT = $clog2(FILTER_US / TICK_US) - 1;
	// ==================================================
	// Sizes and scaling
	localparam int ADC_W = 10;
	localparam int SCALE_SHIFT = 5;
	localparam int N_ADC = 12;
	localparam int N_IO = 14;
	localparam int N_DREG = 32;
	localparam int ADDR_W = 12;
	localparam logic [14:0] MAX_READING = 15'h7FE0;
	// ==================================================
	// Command codes
	localparam logic [7:0] CMD_WAIT_LVL = 8'hC2;
	localparam logic [7:0] CMD_WAIT_DELAY = 8'h8D;
	localparam logic [7:0] CMD_DELAY_LOAD = 8'h8C;
	localparam logic [7:0] CMD_CONT_SAMPLE = 8'hCF;
	localparam logic [7:0] CMD_ONE_SAMPLE = 8'hC1;
	localparam logic [7:0] CMD_CFG_IMM = 8'h1F;
	localparam logic [7:0] CMD_CFG = 8'hBC;
	localparam logic [15:0] MODE_INPUT = 16'hFFFF;
	localparam logic [4:0] DELAY_REG = 5'h05;
	// ==================================================
	// Channel codes
	localparam int CH_VEL = 13;
	localparam int CH_TRQ = 14;
	localparam int CH_PERR = 15;
	// ==================================================
	// Register map, byte addresses
	localparam logic [ADDR_W-1:0] OFF_CODE = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_P1 = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_P2 = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_GO = 12'h00C;
	localparam logic [ADDR_W-1:0] OFF_STAT = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_IO_IN = 12'h014;
	localparam logic [ADDR_W-1:0] OFF_IO_DIR = 12'h018;
	localparam logic [4:0] DREG_BASE = 5'h02;
	localparam int GO_ISSUE_BIT = 0;
	localparam int GO_ABORT_BIT = 1;
	localparam int ST_ACK_BIT = 1;
	localparam int ST_ERR_BIT = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==================================================
	// Sequencer states
	typedef enum logic [2:0]
	{
		S_IDLE = 3'b001,
		S_WLVL = 3'b010,
		S_WDLY = 3'b100
	} cmd_state_t;
endpackage

//--- verilog/servo_tick_if.sv
// Servo tick and shared delay counter link between the unit's modules.
// Assumes all parties run on aclk.
`timescale 1ns/1ps
interface servo_tick_if;
	logic tick;
	logic delay_load;
	logic [31:0] delay_val;
	logic [31:0] delay_count;
	modport timer(output tick, output delay_count, input delay_load, input delay_val);
	modport user(input tick, input delay_count, output delay_load, output delay_val);
	modport listen(input tick);
endinterface

//--- verilog/servo_tick_delay.sv
// Servo tick divider and the delay counter shared by both threads.
// Assumes loads come from the command unit on aclk.
`timescale 1ns/1ps
module servo_tick_delay
	import sv_cmd_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC // Clocks per servo tick
)(
	input logic aclk, // System clock
	input logic aresetn, // Synchronous reset, active low
	servo_tick_if.timer tk // Tick and delay link
);
	typedef struct packed
	{
		logic [31:0] div;
		logic tick;
		logic [31:0] cnt;
	} tdl_t;
	tdl_t s_ff;
	tdl_t nxt_s;
	// ==================================================
	// Divider and countdown
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.tick = 1'b0;
		if (s_ff.div == 32'(TICK_CYCLES - 1))
		begin
			nxt_s.div = 32'h0;
			nxt_s.tick = 1'b1;
		end
		else
			nxt_s.div = s_ff.div + 32'h1;
		// Load beats the tick so a fresh count is never shortened
		if (tk.delay_load)
			nxt_s.cnt = tk.delay_val;
		else if (s_ff.tick && s_ff.cnt != 32'h0)
			nxt_s.cnt = s_ff.cnt - 32'h1;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end
	assign tk.tick = s_ff.tick;
	assign tk.delay_count = s_ff.cnt;
	// ==================================================
	// Checks
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_delay_dec;
		(s_ff.tick && s_ff.cnt != 32'h0 && !tk.delay_load) |=> s_ff.cnt == $past(s_ff.cnt) - 32'h1;
	endproperty
	a_delay_dec: assert property (p_delay_dec) else $error("delay count missed a tick");
	property p_delay_floor;
		(s_ff.cnt == 32'h0 && !tk.delay_load) |=> s_ff.cnt == 32'h0;
	endproperty
	a_delay_floor: assert property (p_delay_floor) else $error("delay count wrapped");
endmodule

//--- verilog/analog_filter_bank.sv
// Background filter of every converter channel, scaled to 15 bits.
// Assumes converter samples are steady on aclk, one 10-bit word a channel.
`timescale 1ns/1ps
module analog_filter_bank
	import sv_cmd_pkg::*;
(
	input logic aclk, // System clock
	input logic aresetn, // Synchronous reset, active low
	servo_tick_if.listen tk, // Servo tick
	input logic [N_ADC*ADC_W-1:0] adc_sample, // Converter words
	output logic [N_ADC-1:0][14:0] filt // Filtered scaled readings
);
	localparam int ACC_W = ADC_W + SCALE_SHIFT + FILT_SHIFT;
	typedef struct packed
	{
		logic [N_ADC-1:0][ACC_W-1:0] acc;
	} afb_t;
	afb_t s_ff;
	afb_t nxt_s;
	// ==================================================
	// Leaky accumulators, one per channel; shift avoids a multiplier
	always_comb
	begin
		nxt_s = s_ff;
		for (int i = 0; i < N_ADC; i++)
		begin
			if (tk.tick)
				nxt_s.acc[i] = s_ff.acc[i] - (s_ff.acc[i] >> FILT_SHIFT)
					+ (ACC_W'(adc_sample[i*ADC_W +: ADC_W]) << SCALE_SHIFT);
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end
	// Settled value equals sample times 32
	for (genvar g = 0; g < N_ADC; g++)
	begin : g_ch
		assign filt[g] = s_ff.acc[g][ACC_W-1 -: 15];
	end
	property p_range;
		@(posedge aclk) disable iff (!aresetn) filt[0] <= MAX_READING;
	endproperty
	a_range: assert property (p_range) else $error("reading above full scale");
endmodule

//--- sim/io_field_model.sv
// Field side of the I/O lines: pins seen by the unit.
// Assumes the bench sets the external sensor level of each line.
`timescale 1ns/1ps
module io_field_model
	import sv_cmd_pkg::*;
(
	input wire logic [N_IO-1:0] io_out, // Unit drive levels
	input wire logic [N_IO-1:0] io_oe, // Unit drive enables
	input wire logic [N_IO-1:0] ext_lvl, // Sensor levels
	output logic [N_IO-1:0] io_in // Resolved pin levels
);
	// ==========
	// Driven line shows the unit, else the sensor
	assign io_in = (io_oe & io_out) | (~io_oe & ext_lvl);
endmodule

//--- sim/tb_top.sv
// Bench of the wait and sampling command unit over AXI4-Lite.
// Assumes a short servo tick so that waits stay brief.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin fail_count++; \
$display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module tb_top;
	import sv_cmd_pkg::*;
	localparam int TK = 20;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, d;
	logic [1:0] r;
	logic [15:0] vel, trq;
	logic [N_IO-1:0] ext;
	logic [N_IO-1:0] io_in, io_out, io_oe;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int fail_count, n_checks, n;
	io_wait_and_analog_sample_cmds #(.TICK_CYCLES(TK)) io_wait_and_analog_sample_cmds_i (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.adc_sample({N_ADC{10'h155}}), .velocity_reading(vel), .torque_reading(trq),
		.poserr_reading(16'h0000), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
	io_field_model io_field_model_i (.io_out(io_out), .io_oe(io_oe), .ext_lvl(ext),
		.io_in(io_in));
	// ==========
	// Bus master: ready and answers are judged at the rising edge, changes follow it
	task wr(input logic [11:0] a, input logic [31:0] v);
		logic aw, w, b;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw = 1'b0;
		w = 1'b0;
		b = 1'b0;
		while (!b)
		begin
			@(posedge aclk);
			b = aw && w && bvalid === 1'b1;
			if (!aw && awready === 1'b1)
			begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1)
			begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		r = bresp;
		bready <= 1'b0;
	endtask
	task rd(input logic [11:0] a);
		logic t, v;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		t = 1'b0;
		v = 1'b0;
		while (!v)
		begin
			@(posedge aclk);
			v = t && rvalid === 1'b1;
			if (!t && arready === 1'b1)
			begin
				t = 1'b1;
				arvalid <= 1'b0;
			end
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// Clears stale flags first so ack belongs to this command
	task cmd(input logic [7:0] c, input logic [15:0] p1, input logic [15:0] p2);
		wr(OFF_STAT, 32'h6);
		wr(OFF_CODE, {24'h0, c});
		wr(OFF_P1, {16'h0, p1});
		wr(OFF_P2, {16'h0, p2});
		wr(OFF_GO, 32'h1);
	endtask
	task idle();
		n = 0;
		rd(OFF_STAT);
		while (d[0] === 1'b1 && n < 200)
		begin
			rd(OFF_STAT);
			n++;
		end
		// A wait that never ends is a mismatch of its own
		if (d[0] !== 1'b0)
			fail_count++;
	endtask
	// ==========
	// Scenarios
	task t_cfg();
		logic [15:0] m [3] = '{16'h0000, 16'h0001, 16'hFFFF};
		`CHK("oe_rst", 14'h0, io_oe)
		for (int i = 0; i < 3; i++)
		begin
			cmd(CMD_CFG_IMM, 16'd3, m[i]);
			`CHK("bresp", RESP_OKAY, r)
			`CHK("oe3", (i < 2), io_oe[2])
			if (i < 2) `CHK("out3", i[0], io_out[2])
		end
	endtask
	task t_single();
		vel <= 16'h8001;
		cmd(CMD_ONE_SAMPLE, 16'd13, 16'd10);
		rd(12'h128);
		`CHK("single", 32'hFFFF8001, d)
		// Same register again, so a stale value would show
		cmd(CMD_ONE_SAMPLE, 16'd0, 16'd10);
		rd(12'h128);
		`CHK("single0", 32'h0, d)
	endtask
	task t_delay();
		wr(12'h114, 32'd6);
		cmd(CMD_WAIT_DELAY, 16'd0, 16'd0);
		rd(OFF_STAT);
		`CHK("dwait", 1'b1, d[4])
		idle();
		`CHK("dack", 1'b1, d[1])
		rd(12'h114);
		`CHK("cnt0", 32'h0, d)
		cmd(CMD_DELAY_LOAD, 16'hFFFD, 16'd0);
		rd(12'h114);
		`CHK("neg", 1'b1, d > 0 && d <= 3)
	endtask
	task t_lvl();
		ext <= '0;
		cmd(CMD_WAIT_LVL, 16'd2, 16'd1);
		repeat (3 * TK) @(posedge aclk);
		rd(OFF_STAT);
		`CHK("lwait", 1'b1, d[3])
		cmd(CMD_CFG_IMM, 16'd2, 16'd1);
		idle();
		`CHK("lexit", 1'b1, n < TK)
		`CHK("lerr", 1'b0, d[2])
		cmd(CMD_WAIT_LVL, 16'd2, 16'd1);
		rd(OFF_STAT);
		`CHK("lnow", 2'b10, d[1:0])
	endtask
	task t_cont();
		trq <= 16'h0123;
		cmd(CMD_CONT_SAMPLE, 16'd14, 16'd20);
		repeat (2 * TK) @(posedge aclk);
		rd(12'h150);
		`CHK("cont", 32'h123, d)
		trq <= 16'hFF00;
		repeat (2 * TK) @(posedge aclk);
		rd(12'h150);
		`CHK("cont2", 32'hFFFFFF00, d)
		cmd(CMD_CONT_SAMPLE, 16'd0, 16'd20);
		wr(12'h150, 32'h5);
		repeat (2 * TK) @(posedge aclk);
		rd(12'h150);
		`CHK("cont0", 32'h5, d)
		// Half-weight low pass from 5 toward -256: one or two ticks land in between
		cmd(CMD_CONT_SAMPLE, 16'h800E, 16'd20);
		repeat (TK) @(posedge aclk);
		rd(12'h150);
		`CHK("lpf", 1'b1, d > 32'hFFFFFF00)
		rd(12'h200);
		`CHK("unmap", RESP_SLVERR, r)
	endtask
	task report_and_stop();
		$display("checks %0d fails %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ==========
	// Clock
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// Reset, then each scenario in turn
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, vel, trq, ext} = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_cfg();
		t_single();
		t_delay();
		t_lvl();
		t_cont();
		report_and_stop();
	end
	// Watchdog at 10000 cycles, far beyond the expected run of under a thousand cycles
	initial
	begin
		#100000;
		fail_count++;
		report_and_stop();
	end
endmodule
